// ==== logic/tcs_pkg.sv ====
// package: shared constants of the timeline command scheduler
package tcs_pkg;
	// sizes
	localparam int unsigned NENT = 8;
	localparam int unsigned SW = 3;
	localparam int unsigned NILK = 16;
	localparam int unsigned IW = 4;
	localparam int unsigned TW = 48;
	localparam int unsigned AW = 11;
	localparam int unsigned PW = 32;
	localparam int unsigned CW = 4;
	localparam int unsigned RAW = 4;
	localparam int unsigned DW = 32;
	localparam int unsigned STW = 8;
	// request subtypes
	localparam logic [STW-1:0] ST_ENABLE = 8'h01;
	localparam logic [STW-1:0] ST_DISABLE = 8'h02;
	localparam logic [STW-1:0] ST_RESET = 8'h03;
	localparam logic [STW-1:0] ST_INSERT = 8'h04;
	// scheduling event codes and assessment
	localparam logic [1:0] EV_ABS = 2'h0;
	localparam logic [1:0] EV_SCHED = 2'h1;
	localparam logic [1:0] EV_ILK = 2'h3;
	localparam logic ASSESS_OK = 1'b1;
	localparam logic [IW-1:0] ILK_NONE = 4'h0;
	localparam logic [CW-1:0] CNT_ALL = 4'h0;
	// source part of the embedded packet's sequence control
	localparam logic [2:0] SRC_TIMELINE = 3'h1;
	localparam int unsigned SRC_MSB = 31;
	localparam int unsigned SRC_LSB = 29;
	// register map
	localparam logic [RAW-1:0] REG_CTRL = 4'h0;
	localparam logic [RAW-1:0] REG_STATUS = 4'h4;
	localparam int unsigned CTRL_ILK = 0;
	localparam int unsigned CTRL_REL = 1;
	localparam logic [1:0] CTRL_RST = 2'h3;
	localparam int unsigned STS_SCHED = 0;
	localparam int unsigned STS_OCC_LSB = 4;
	localparam int unsigned STS_REJ_LSB = 8;
	localparam logic [7:0] REJ_MAX = 8'hff;
endpackage

// ==== logic/tcs_pkt_mem.sv ====
// packet store: one command word per schedule slot, registered read
`timescale 1ns/1ns
`default_nettype none
module tcs_pkt_mem (
	input wire logic ref_clk_i,
	input wire logic sys_rst_i,
	input wire logic wr_en_i,
	input wire logic [tcs_pkg::SW-1:0] wr_addr_i,
	input wire logic [tcs_pkg::PW-1:0] wr_data_i,
	input wire logic [tcs_pkg::SW-1:0] rd_addr_i,
	output logic [tcs_pkg::PW-1:0] rd_data_o
);
	typedef struct packed {
		logic [tcs_pkg::NENT-1:0][tcs_pkg::PW-1:0] mem;
		logic [tcs_pkg::PW-1:0] rd;
	} tcs_mem_t;
	tcs_mem_t st_reg;
	tcs_mem_t st_next;

	// read every cycle so the word lands beside the release strobe
	always_comb begin
		st_next = st_reg;
		st_next.rd = st_reg.mem[rd_addr_i];
		if (wr_en_i) begin
			st_next.mem[wr_addr_i] = wr_data_i;
		end
	end

	always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign rd_data_o = st_reg.rd;
endmodule
`default_nettype wire

// ==== logic/tcs_scheduler.sv ====
// timeline command scheduler: stores, gates and releases timed commands
//
// Contract
// - release only when interlock conditions hold
// - a failed release leaves other entries alone
// - judge release preconditions at execution time
// - erroneous operation leaves the schedule unchanged
// - count zero enables or disables every destination
// - enable/disable sets entry attribute, enable records time
// - enabled timeline runs from present time onward
// - reset clears entries, interlocks, event times
// - one command packet per insert request
// - insert fields arrive in documented order
// - set-interlock zero sets none, else takes outcome
// - check-interlock zero means no dependency
// - interlock fields absent without interlock support
// - assessment 1 needs success, 0 needs failure
// - event codes: 0 absolute, 1 schedule, 3 interlock
// - event field absent without relative support
// - relative release is event time plus delta
// - timeout only for setters; release plus timeout
// - missing completion by deadline means failure
// - on timeout event time becomes the deadline
// - bind to latest setter of that interlock
// - check consistency before storing an insert
//
// Our own choices: the address-and-strobe port and the address map.
`timescale 1ns/1ns
`default_nettype none
module tcs_scheduler (
	input wire logic ref_clk_i,
	input wire logic sys_rst_i,
	input wire logic [tcs_pkg::TW-1:0] onboard_time_i,
	input wire logic req_valid_i,
	input wire logic [tcs_pkg::STW-1:0] req_subtype_i,
	input wire logic [tcs_pkg::CW-1:0] req_count_i,
	input wire logic [tcs_pkg::AW-1:0] req_destination_process_id_i,
	input wire logic [tcs_pkg::IW-1:0] ins_iset_i,
	input wire logic [tcs_pkg::IW-1:0] ins_ichk_i,
	input wire logic ins_assess_i,
	input wire logic [1:0] ins_event_i,
	input wire logic [tcs_pkg::TW-1:0] ins_tag_i,
	input wire logic [tcs_pkg::TW-1:0] ins_tmo_i,
	input wire logic [tcs_pkg::PW-1:0] ins_pkt_i,
	input wire logic done_valid_i,
	input wire logic [tcs_pkg::IW-1:0] done_ilk_i,
	input wire logic done_ok_i,
	input wire logic [tcs_pkg::RAW-1:0] bus_addr_i,
	input wire logic [tcs_pkg::DW-1:0] bus_wdata_i,
	input wire logic bus_wr_i,
	input wire logic bus_rd_i,
	output logic [tcs_pkg::DW-1:0] bus_rdata_o,
	output logic req_ack_o,
	output logic req_err_o,
	output logic rel_valid_o,
	output logic [tcs_pkg::AW-1:0] rel_destination_process_id_o,
	output logic [tcs_pkg::PW-1:0] rel_pkt_o
);
	localparam int unsigned NENT = tcs_pkg::NENT;
	localparam int unsigned NILK = tcs_pkg::NILK;
	localparam int unsigned SW = tcs_pkg::SW;
	localparam int unsigned IW = tcs_pkg::IW;
	localparam int unsigned TW = tcs_pkg::TW;

	typedef struct packed {
		logic vld;
		logic en;
		logic [tcs_pkg::AW-1:0] destination_process_id;
		logic [IW-1:0] iset;
		logic [IW-1:0] ichk;
		logic asg;
		logic [1:0] ev;
		logic [TW-1:0] tag;
		logic [TW-1:0] tmo;
	} tcs_ent_t;

	typedef struct packed {
		tcs_ent_t [NENT-1:0] ent;
		logic [NILK-1:0] ik_known;
		logic [NILK-1:0] ik_ok;
		logic [NILK-1:0] ik_armed;
		logic [NILK-1:0][TW-1:0] ik_time;
		logic [NILK-1:0][TW-1:0] ik_dl;
		logic sched_known;
		logic [TW-1:0] sched_time;
		logic [1:0] ctrl;
		logic [7:0] rej;
		logic ack;
		logic err;
		logic rel;
		logic [tcs_pkg::AW-1:0] rel_destination_process_id;
		logic [tcs_pkg::DW-1:0] rdata;
	} tcs_state_t;

	tcs_state_t st_reg;
	tcs_state_t st_next;
	logic [NENT-1:0] due;
	logic [NENT-1:0] pass;
	logic [NENT-1:0] en_vec;
	logic sel_found;
	logic [SW-1:0] sel;
	logic free_found;
	logic [SW-1:0] free;
	logic [SW:0] occ;
	logic ins_ok;
	logic wr_en;
	logic [SW-1:0] rd_addr;
	logic [TW-1:0] now;

	assign now = onboard_time_i;

	// per-slot release test, redone every cycle from current state
	for (genvar g = 0; g < NENT; g++) begin : g_ent
		tcs_ent_t e;
		logic bknown;
		logic ck;
		logic [TW-1:0] base;
		logic [TW-1:0] rel_t;
		assign e = st_reg.ent[g];
		// relative tags add to the referenced event time
		assign base = (e.ev == tcs_pkg::EV_SCHED) ? st_reg.sched_time :
			(e.ev == tcs_pkg::EV_ILK) ? st_reg.ik_time[e.ichk] : '0;
		assign bknown = (e.ev == tcs_pkg::EV_SCHED) ? st_reg.sched_known :
			(e.ev == tcs_pkg::EV_ILK) ? st_reg.ik_known[e.ichk] : 1'b1;
		// an unresolved interlock holds the entry back
		assign ck = (e.ichk == tcs_pkg::ILK_NONE) | st_reg.ik_known[e.ichk];
		assign rel_t = base + e.tag;
		assign due[g] = e.vld & e.en & bknown & ck & (now >= rel_t);
		assign pass[g] = (e.ichk == tcs_pkg::ILK_NONE) |
			(st_reg.ik_ok[e.ichk] == e.asg);
		assign en_vec[g] = e.en;
	end

	// slot search kept apart so the insert check never loops back into it
	always_comb begin
		sel_found = 1'b0;
		sel = '0;
		free_found = 1'b0;
		free = '0;
		occ = '0;
		// lowest due slot wins; others wait one more cycle
		for (int i = 0; i < NENT; i++) begin
			if (!sel_found && due[i]) begin
				sel_found = 1'b1;
				sel = SW'(i);
			end
			if (!free_found && !st_reg.ent[i].vld) begin
				free_found = 1'b1;
				free = SW'(i);
			end
			occ = occ + {{SW{1'b0}}, st_reg.ent[i].vld};
		end
	end

	// consistency check of an insert against mode bits and the timeline
	assign ins_ok = free_found &
		(ins_event_i == tcs_pkg::EV_ABS || ins_event_i == tcs_pkg::EV_SCHED ||
		ins_event_i == tcs_pkg::EV_ILK) &
		(st_reg.ctrl[tcs_pkg::CTRL_ILK] |
		(ins_iset_i == tcs_pkg::ILK_NONE && ins_ichk_i == tcs_pkg::ILK_NONE)) &
		(st_reg.ctrl[tcs_pkg::CTRL_REL] | (ins_event_i == tcs_pkg::EV_ABS)) &
		((ins_event_i != tcs_pkg::EV_ILK) | (ins_ichk_i != tcs_pkg::ILK_NONE)) &
		((ins_iset_i == tcs_pkg::ILK_NONE) | (ins_iset_i != ins_ichk_i)) &
		(ins_pkt_i[tcs_pkg::SRC_MSB:tcs_pkg::SRC_LSB] == tcs_pkg::SRC_TIMELINE);

	// next-state logic: outcomes, release, requests, register bus
	always_comb begin
		st_next = st_reg;
		st_next.ack = 1'b0;
		st_next.err = 1'b0;
		st_next.rel = 1'b0;
		st_next.rdata = '0;
		wr_en = 1'b0;
		rd_addr = '0;
		// completion report wins over a deadline hit in the same cycle
		for (int k = 1; k < NILK; k++) begin
			if (st_reg.ik_armed[k]) begin
				if (done_valid_i && done_ilk_i == IW'(k)) begin
					st_next.ik_known[k] = 1'b1;
					st_next.ik_ok[k] = done_ok_i;
					st_next.ik_time[k] = now;
					st_next.ik_armed[k] = 1'b0;
				end else if (now >= st_reg.ik_dl[k]) begin
					st_next.ik_known[k] = 1'b1;
					st_next.ik_ok[k] = 1'b0;
					st_next.ik_time[k] = st_reg.ik_dl[k];
					st_next.ik_armed[k] = 1'b0;
				end
			end
		end
		// release: a failed gate drops only this slot
		if (sel_found) begin
			st_next.ent[sel].vld = 1'b0;
			if (pass[sel]) begin
				st_next.rel = 1'b1;
				st_next.rel_destination_process_id = st_reg.ent[sel].destination_process_id;
				rd_addr = sel;
				if (st_reg.ent[sel].iset != tcs_pkg::ILK_NONE) begin
					st_next.ik_armed[st_reg.ent[sel].iset] = 1'b1;
					st_next.ik_known[st_reg.ent[sel].iset] = 1'b0;
					st_next.ik_dl[st_reg.ent[sel].iset] = now + st_reg.ent[sel].tmo;
				end
			end else if (st_reg.ent[sel].iset != tcs_pkg::ILK_NONE) begin
				// never sent counts as failed so dependents still resolve
				st_next.ik_known[st_reg.ent[sel].iset] = 1'b1;
				st_next.ik_ok[st_reg.ent[sel].iset] = 1'b0;
				st_next.ik_time[st_reg.ent[sel].iset] = now;
				st_next.ik_armed[st_reg.ent[sel].iset] = 1'b0;
			end
		end
		// requests from the command source, one per cycle
		if (req_valid_i) begin
			case (req_subtype_i)
				tcs_pkg::ST_ENABLE, tcs_pkg::ST_DISABLE: begin
					for (int i = 0; i < NENT; i++) begin
						if (req_count_i == tcs_pkg::CNT_ALL ||
							st_reg.ent[i].destination_process_id == req_destination_process_id_i) begin
							st_next.ent[i].en = (req_subtype_i == tcs_pkg::ST_ENABLE);
							// absolute times already past are not run late
							if (req_subtype_i == tcs_pkg::ST_ENABLE &&
								st_reg.ent[i].ev == tcs_pkg::EV_ABS &&
								st_reg.ent[i].tag < now) begin
								st_next.ent[i].vld = 1'b0;
							end
						end
					end
					if (req_subtype_i == tcs_pkg::ST_ENABLE) begin
						st_next.sched_known = 1'b1;
						st_next.sched_time = now;
					end
					st_next.ack = 1'b1;
				end
				tcs_pkg::ST_RESET: begin
					for (int i = 0; i < NENT; i++) begin
						st_next.ent[i].vld = 1'b0;
					end
					st_next.ik_known = '0;
					st_next.ik_armed = '0;
					st_next.sched_known = 1'b0;
					st_next.ack = 1'b1;
				end
				tcs_pkg::ST_INSERT: begin
					if (ins_ok) begin
						// one packet per request, fields already split in order
						st_next.ent[free].vld = 1'b1;
						st_next.ent[free].en = 1'b0;
						st_next.ent[free].destination_process_id = req_destination_process_id_i;
						st_next.ent[free].iset = ins_iset_i;
						st_next.ent[free].ichk = ins_ichk_i;
						st_next.ent[free].asg = ins_assess_i;
						st_next.ent[free].ev = ins_event_i;
						st_next.ent[free].tag = ins_tag_i;
						st_next.ent[free].tmo = (ins_iset_i == tcs_pkg::ILK_NONE) ?
							'0 : ins_tmo_i;
						wr_en = 1'b1;
						// a new setter supersedes older outcomes of that id
						if (ins_iset_i != tcs_pkg::ILK_NONE) begin
							st_next.ik_known[ins_iset_i] = 1'b0;
						end
						st_next.ack = 1'b1;
					end else begin
						st_next.err = 1'b1;
					end
				end
				default: begin
					st_next.err = 1'b1;
				end
			endcase
		end
		if (st_next.err && st_reg.rej != tcs_pkg::REJ_MAX) begin
			st_next.rej = st_reg.rej + 8'h01;
		end
		// register bus: unmapped reads return zero, writes ignored
		if (bus_wr_i && bus_addr_i == tcs_pkg::REG_CTRL) begin
			st_next.ctrl = bus_wdata_i[1:0];
		end
		if (bus_rd_i) begin
			if (bus_addr_i == tcs_pkg::REG_CTRL) begin
				st_next.rdata[1:0] = st_reg.ctrl;
			end else if (bus_addr_i == tcs_pkg::REG_STATUS) begin
				st_next.rdata[tcs_pkg::STS_SCHED] = st_reg.sched_known;
				st_next.rdata[tcs_pkg::STS_OCC_LSB +: SW+1] = occ;
				st_next.rdata[tcs_pkg::STS_REJ_LSB +: 8] = st_reg.rej;
			end
		end
	end

	// state register
	always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			st_reg <= '0;
			st_reg.ctrl <= tcs_pkg::CTRL_RST;
		end else begin
			st_reg <= st_next;
		end
	end

	// packet words live apart from the timing state
	tcs_pkt_mem u_mem (
		.ref_clk_i(ref_clk_i),
		.sys_rst_i(sys_rst_i),
		.wr_en_i(wr_en),
		.wr_addr_i(free),
		.wr_data_i(ins_pkt_i),
		.rd_addr_i(rd_addr),
		.rd_data_o(rel_pkt_o)
	);

	assign bus_rdata_o = st_reg.rdata;
	assign req_ack_o = st_reg.ack;
	assign req_err_o = st_reg.err;
	assign rel_valid_o = st_reg.rel;
	assign rel_destination_process_id_o = st_reg.rel_destination_process_id;

	// checks on the scheduler's own behaviour
	default clocking cb @(posedge ref_clk_i);
	endclocking
	default disable iff (sys_rst_i);

	sequence s_pick_pass;
		sel_found && pass[sel];
	endsequence
	sequence s_pick_fail;
		sel_found && !pass[sel];
	endsequence
	sequence s_req(logic [tcs_pkg::STW-1:0] st);
		req_valid_i && req_subtype_i == st;
	endsequence
	sequence s_good_ins;
		s_req(tcs_pkg::ST_INSERT) and ins_ok;
	endsequence

	AST_REL_GATED: assert property (s_pick_pass |=> rel_valid_o)
		else $error("passing due entry not released");
	AST_REL_CAUSE: assert property (rel_valid_o |-> $past(sel_found))
		else $error("release without a due entry");
	AST_FAIL_NO_REL: assert property (s_pick_fail |=> !rel_valid_o)
		else $error("entry released against its interlock");
	AST_RESET_CLR: assert property (s_req(tcs_pkg::ST_RESET)
		|=> occ == '0 && !st_reg.sched_known && st_reg.ik_known == '0)
		else $error("reset request left state behind");
	AST_ALL_OFF: assert property (s_req(tcs_pkg::ST_DISABLE) and
		req_count_i == tcs_pkg::CNT_ALL |=> en_vec == '0 ##1 !rel_valid_o)
		else $error("disable all left an entry enabled");
	AST_EN_TIME: assert property (s_req(tcs_pkg::ST_ENABLE)
		|=> st_reg.sched_known && st_reg.sched_time == $past(now))
		else $error("enable time not recorded");
	AST_INS_STORE: assert property (s_good_ins
		|=> req_ack_o && st_reg.ent[$past(free)].vld)
		else $error("good insert not stored");
	AST_BAD_INS: assert property (s_req(tcs_pkg::ST_INSERT) and !ins_ok
		|=> req_err_o && !req_ack_o && occ <= $past(occ))
		else $error("bad insert not refused");
	AST_BAD_SUB: assert property (req_valid_i && req_subtype_i >
		tcs_pkg::ST_INSERT |=> req_err_o)
		else $error("unknown subtype not refused");
	for (genvar k = 1; k < NILK; k++) begin : g_tmo
		AST_TIMEOUT: assert property (st_reg.ik_armed[k] &&
			now >= st_reg.ik_dl[k] && !(done_valid_i && done_ilk_i == IW'(k)) &&
			!(sel_found && st_reg.ent[sel].iset == IW'(k)) &&
			!(req_valid_i && req_subtype_i == tcs_pkg::ST_RESET) &&
			!(req_valid_i &&
			req_subtype_i == tcs_pkg::ST_INSERT && ins_iset_i == IW'(k))
			|=> st_reg.ik_known[k] && !st_reg.ik_ok[k] &&
			st_reg.ik_time[k] == $past(st_reg.ik_dl[k]))
			else $error("timeout did not fail the interlock");
	end
endmodule
`default_nettype wire

// ==== testbench/tcs_user_model.sv ====
// end-user model: takes released commands and reports completion of the non-silent ones that name an interlock
`timescale 1ns/1ns
`default_nettype none
module tcs_user_model (
	input wire logic ref_clk_i,
	input wire logic sys_rst_i,
	input wire logic rel_valid_i,
	input wire logic [tcs_pkg::PW-1:0] rel_pkt_i,
	output logic done_valid_o,
	output logic [tcs_pkg::IW-1:0] done_ilk_o,
	output logic done_ok_o
);
	logic [3:0] wait_reg;
	logic [tcs_pkg::PW-1:0] pkt_reg;
	// packet low bits: [3:0] interlock, [4] ok, [7:5] delay, [8] silent
	always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			wait_reg <= 4'h0;
			pkt_reg <= 32'h0;
			done_valid_o <= 1'b0;
			done_ilk_o <= 4'h0;
			done_ok_o <= 1'b0;
		end else begin
			done_valid_o <= 1'b0;
			// idle lines toggle so a stale id is never mistaken for a report
			done_ilk_o <= ~done_ilk_o;
			done_ok_o <= ~done_ok_o;
			if (rel_valid_i && rel_pkt_i[3:0] != 4'h0 && !rel_pkt_i[8]) begin
				pkt_reg <= rel_pkt_i;
				wait_reg <= {1'b0, rel_pkt_i[7:5]} + 4'h1;
			end else if (wait_reg != 4'h0) begin
				wait_reg <= wait_reg - 4'h1;
				if (wait_reg == 4'h1) begin
					done_valid_o <= 1'b1;
					done_ilk_o <= pkt_reg[3:0];
					done_ok_o <= pkt_reg[4];
				end
			end
		end
	end
endmodule
`default_nettype wire

// ==== testbench/timeline_command_scheduler_test.sv ====
// testbench: request, register and release checks of the scheduler
`timescale 1ns/1ns
`default_nettype none
module timeline_command_scheduler_test;
	logic ref_clk_i = 1'b0;
	logic sys_rst_i = 1'b1;
	logic [47:0] tnow = 48'h100;
	logic req_valid_i = 1'b0;
	logic [7:0] req_subtype_i = 8'h0;
	logic [3:0] req_count_i = 4'h0;
	logic [10:0] req_destination_process_id_i = 11'h0;
	logic [3:0] ins_iset_i = 4'h0;
	logic [3:0] ins_ichk_i = 4'h0;
	logic ins_assess_i = 1'b0;
	logic [1:0] ins_event_i = 2'h0;
	logic [47:0] ins_tag_i = 48'h0;
	logic [47:0] ins_tmo_i = 48'h0;
	logic [31:0] ins_pkt_i = 32'h0;
	logic done_valid_i;
	logic [3:0] done_ilk_i;
	logic done_ok_i;
	logic [3:0] bus_addr_i = 4'h0;
	logic [31:0] bus_wdata_i = 32'h0;
	logic bus_wr_i = 1'b0;
	logic bus_rd_i = 1'b0;
	logic [31:0] bus_rdata_o;
	logic req_ack_o;
	logic req_err_o;
	logic rel_valid_o;
	logic [10:0] rel_destination_process_id_o;
	logic [31:0] rel_pkt_o;
	logic [31:0] v;
	logic [47:0] t0;
	logic [47:0] tr;
	int errors = 0;
	int total_checks = 0;
	int rel_cnt = 0;
	tcs_scheduler i_dut (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i),
		.onboard_time_i(tnow), .req_valid_i(req_valid_i),
		.req_subtype_i(req_subtype_i), .req_count_i(req_count_i),
		.req_destination_process_id_i(req_destination_process_id_i), .ins_iset_i(ins_iset_i),
		.ins_ichk_i(ins_ichk_i), .ins_assess_i(ins_assess_i),
		.ins_event_i(ins_event_i), .ins_tag_i(ins_tag_i),
		.ins_tmo_i(ins_tmo_i), .ins_pkt_i(ins_pkt_i),
		.done_valid_i(done_valid_i), .done_ilk_i(done_ilk_i),
		.done_ok_i(done_ok_i), .bus_addr_i(bus_addr_i),
		.bus_wdata_i(bus_wdata_i), .bus_wr_i(bus_wr_i), .bus_rd_i(bus_rd_i),
		.bus_rdata_o(bus_rdata_o), .req_ack_o(req_ack_o),
		.req_err_o(req_err_o), .rel_valid_o(rel_valid_o),
		.rel_destination_process_id_o(rel_destination_process_id_o), .rel_pkt_o(rel_pkt_o));
	tcs_user_model i_user (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i),
		.rel_valid_i(rel_valid_o), .rel_pkt_i(rel_pkt_o),
		.done_valid_o(done_valid_i), .done_ilk_o(done_ilk_i),
		.done_ok_o(done_ok_i));
	// clock, running on-board time and release counter
	always #5 ref_clk_i = ~ref_clk_i;
	always @(posedge ref_clk_i) begin
		tnow <= tnow + 48'h1;
		if (rel_valid_o === 1'b1)
			rel_cnt <= rel_cnt + 1;
	end
	task complete_run;
		if (errors == 0 && total_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task chk(input logic [47:0] got, input logic [47:0] exp);
		total_checks++;
		if (got !== exp) begin
			errors++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task rd(input logic [3:0] a, output logic [31:0] d);
		@(posedge ref_clk_i);
		bus_rd_i <= 1'b1;
		bus_addr_i <= a;
		@(posedge ref_clk_i);
		bus_rd_i <= 1'b0;
		#1 d = bus_rdata_o;
	endtask
	task wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge ref_clk_i);
		bus_wr_i <= 1'b1;
		bus_addr_i <= a;
		bus_wdata_i <= d;
		@(posedge ref_clk_i);
		bus_wr_i <= 1'b0;
	endtask
	// one request beat; answer is sampled in the cycle after it is taken
	task req(input logic [7:0] st, input logic [3:0] cn, input logic [10:0] ap,
		input logic [3:0] is, input logic [3:0] ic, input logic as,
		input logic [1:0] ev, input logic [47:0] tg, input logic [47:0] tm,
		input logic [31:0] pk, input logic bad);
		@(posedge ref_clk_i);
		req_valid_i <= 1'b1;
		req_subtype_i <= st;
		req_count_i <= cn;
		req_destination_process_id_i <= ap;
		ins_iset_i <= is;
		ins_ichk_i <= ic;
		ins_assess_i <= as;
		ins_event_i <= ev;
		ins_tag_i <= tg;
		ins_tmo_i <= tm;
		ins_pkt_i <= pk;
		@(posedge ref_clk_i);
		req_valid_i <= 1'b0;
		#1 chk(req_err_o, bad);
		chk(req_ack_o, !bad);
	endtask
	// waits for a release and checks its target, payload and instant
	task wait_rel(input logic [10:0] ap, input logic [31:0] pk,
		input logic [47:0] lo);
		int n;
		n = 0;
		do begin
			@(posedge ref_clk_i);
			#1 n++;
		end while (rel_valid_o !== 1'b1 && n < 300);
		tr = tnow;
		chk(rel_destination_process_id_o, ap);
		chk(rel_pkt_o, pk);
		chk(tr >= lo && tr <= lo + 48'd6, 1'b1);
	endtask
	initial begin
		repeat (3) @(posedge ref_clk_i);
		sys_rst_i <= 1'b0;
		rd(tcs_pkg::REG_CTRL, v);
		chk(v, 32'h3);
		rd(tcs_pkg::REG_STATUS, v);
		chk(v, 32'h0);
		rd(4'h8, v);
		chk(v, 32'h0);
		// refused requests must leave the schedule empty
		req(8'h05, 0, 11'h1, 0, 0, 0, 0, 0, 0, 32'h2000_0000, 1);
		req(tcs_pkg::ST_INSERT, 0, 11'h1, 0, 0, 0, 2, 9, 0, 32'h2000_0000, 1);
		req(tcs_pkg::ST_INSERT, 0, 11'h1, 0, 0, 0, 0, 9, 0, 32'h4000_0000, 1);
		req(tcs_pkg::ST_INSERT, 0, 11'h1, 3, 3, 0, 0, 9, 9, 32'h2000_0000, 1);
		req(tcs_pkg::ST_INSERT, 0, 11'h1, 0, 0, 0, 3, 9, 0, 32'h2000_0000, 1);
		wr(tcs_pkg::REG_CTRL, 32'h2);
		req(tcs_pkg::ST_INSERT, 0, 11'h1, 1, 0, 0, 0, 9, 9, 32'h2000_0000, 1);
		wr(tcs_pkg::REG_CTRL, 32'h1);
		rd(tcs_pkg::REG_CTRL, v);
		chk(v, 32'h1);
		req(tcs_pkg::ST_INSERT, 0, 11'h1, 0, 0, 0, 1, 9, 0, 32'h2000_0000, 1);
		wr(tcs_pkg::REG_CTRL, 32'h3);
		rd(tcs_pkg::REG_STATUS, v);
		chk(v, 32'h0000_0700);
		// setter, success-gated and failure-gated dependants, past entry
		t0 = tnow;
		req(tcs_pkg::ST_INSERT, 0, 11'h10, 1, 0, 0, 0, t0 + 40, 48'h40, 32'h20aa_0031, 0);
		req(tcs_pkg::ST_INSERT, 0, 11'h20, 0, 1, 1, 3, 5, 0, 32'h20bb_0000, 0);
		req(tcs_pkg::ST_INSERT, 0, 11'h30, 0, 1, 0, 3, 5, 0, 32'h20cc_0000, 0);
		req(tcs_pkg::ST_INSERT, 0, 11'h90, 0, 0, 0, 0, t0 + 1, 0, 32'h20dd_0000, 0);
		req(tcs_pkg::ST_ENABLE, 0, 11'h0, 0, 0, 0, 0, 0, 0, 32'h0, 0);
		wait_rel(11'h10, 32'h20aa_0031, t0 + 40);
		wait_rel(11'h20, 32'h20bb_0000, tr + 5);
		repeat (20) @(posedge ref_clk_i);
		chk(rel_cnt, 2);
		// schedule reset, then timeout and schedule-relative timing
		req(tcs_pkg::ST_RESET, 0, 11'h0, 0, 0, 0, 0, 0, 0, 32'h0, 0);
		rd(tcs_pkg::REG_STATUS, v);
		chk(v[7:0], 8'h00);
		t0 = tnow;
		req(tcs_pkg::ST_INSERT, 0, 11'h60, 2, 0, 0, 0, t0 + 40, 48'd20, 32'h2060_0102, 0);
		req(tcs_pkg::ST_INSERT, 0, 11'h70, 0, 2, 0, 3, 4, 0, 32'h2070_0000, 0);
		req(tcs_pkg::ST_INSERT, 0, 11'h80, 0, 0, 0, 1, 12, 0, 32'h2080_0000, 0);
		req(tcs_pkg::ST_ENABLE, 0, 11'h0, 0, 0, 0, 0, 0, 0, 32'h0, 0);
		wait_rel(11'h80, 32'h2080_0000, tnow + 11);
		wait_rel(11'h60, 32'h2060_0102, t0 + 40);
		wait_rel(11'h70, 32'h2070_0000, tr + 23);
		// enable one destination by count and id, the other stays held
		t0 = tnow;
		req(tcs_pkg::ST_INSERT, 0, 11'h44, 0, 0, 0, 0, t0 + 20, 0, 32'h2044_0000, 0);
		req(tcs_pkg::ST_INSERT, 0, 11'h45, 0, 0, 0, 0, t0 + 20, 0, 32'h2045_0000, 0);
		req(tcs_pkg::ST_ENABLE, 1, 11'h44, 0, 0, 0, 0, 0, 0, 32'h0, 0);
		wait_rel(11'h44, 32'h2044_0000, t0 + 20);
		repeat (30) @(posedge ref_clk_i);
		chk(rel_cnt, 6);
		rd(tcs_pkg::REG_STATUS, v);
		chk(v[7:0], 8'h11);
		// enable all drops the stale entry, disable all holds the new one
		t0 = tnow;
		req(tcs_pkg::ST_INSERT, 0, 11'h46, 0, 0, 0, 0, t0 + 20, 0, 32'h2046_0000, 0);
		req(tcs_pkg::ST_ENABLE, 0, 11'h0, 0, 0, 0, 0, 0, 0, 32'h0, 0);
		req(tcs_pkg::ST_DISABLE, 0, 11'h0, 0, 0, 0, 0, 0, 0, 32'h0, 0);
		repeat (30) @(posedge ref_clk_i);
		chk(rel_cnt, 6);
		rd(tcs_pkg::REG_STATUS, v);
		chk(v[15:0], 16'h0711);
		complete_run();
	end
	// watchdog well beyond the few hundred cycles the tests take
	initial begin
		#200000;
		errors++;
		complete_run();
	end
endmodule
`default_nettype wire
